// *** psf_cmd.sv ***
`timescale 1ns/1ps
`include "psf_defines.svh"

// Overview of operation
// - Escape 0x47 plus one byte; starts off
// - Only parameter bit zero sets double strike
// - Double strike prints as emphasized
// - Double strike only on single-byte characters
// - Escape 0x4a: print, feed n times unit
// - After feed, go to next line start
// - Standard mode feeds by vertical unit
// - Page mode UL/LR corner: vertical unit
// - Page mode UR/LL corner: horizontal unit
// - Feed clamped to 150 mm maximum
// - Emphasis set by its parameter bit zero
module psf_cmd (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire psf_pkg::psf_axi_req_t axi_req,
  output psf_pkg::psf_axi_rsp_t      axi_rsp,
  input  wire psf_pkg::psf_byte_t    host_byte,
  output logic               host_ready,
  input  wire logic          char_single_byte,
  output logic               bold_active,
  output psf_pkg::psf_feed_t feed_out,
  output logic               line_start
);
  import psf_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State

  psf_state_t  state_r;          // Parser state
  psf_state_t  state_nxt;        // Next parser state
  logic        dstrike_r;        // Double-strike flag
  logic        emph_r;           // Emphasis flag
  logic [31:0] ctrl_r;           // Mode and corner
  logic [15:0] unit_x_r;         // Horizontal unit, um
  logic [15:0] unit_y_r;         // Vertical unit, um
  logic [31:0] feed_r;           // Last feed distance
  psf_feed_t   feed_r_out;       // Feed order register
  logic        line_start_r;     // Next-line pulse
  logic        bvalid_r;         // Write answer pending
  logic [1:0]  bresp_r;          // Write answer code
  logic        rvalid_r;         // Read answer pending
  logic [1:0]  rresp_r;          // Read answer code
  logic [31:0] rdata_r;          // Read data

  //////////////////////////////////////////////////////////////////////////
  // Byte stream decoding

  // Every byte is taken; the parser never stalls the host
  assign host_ready = 1'b1;

  wire         byte_take  = host_byte.valid;
  wire  [7:0]  byte_val   = host_byte.data;
  wire         is_esc     = byte_val == `PSF_ESC_BYTE;
  wire         param_g    = byte_take && (state_r == PSF_ST_PAR_G);
  wire         param_j    = byte_take && (state_r == PSF_ST_PAR_J);
  wire         param_e    = byte_take && (state_r == PSF_ST_PAR_E);

  // Parser next state
  always_comb begin
    state_nxt = state_r;
    if (byte_take) begin
      case (state_r)
        PSF_ST_IDLE: begin
          // Plain data bytes are left to the print path
          state_nxt = is_esc ? PSF_ST_ESC : PSF_ST_IDLE;
        end
        PSF_ST_ESC: begin
          case (byte_val)
            `PSF_OP_DSTRIKE: state_nxt = PSF_ST_PAR_G;
            `PSF_OP_FEED:    state_nxt = PSF_ST_PAR_J;
            `PSF_OP_EMPH:    state_nxt = PSF_ST_PAR_E;
            // Other commands are decoded elsewhere
            default:         state_nxt = PSF_ST_IDLE;
          endcase
        end
        // One parameter byte, then straight back to idle
        PSF_ST_PAR_G: state_nxt = PSF_ST_IDLE;
        PSF_ST_PAR_J: state_nxt = PSF_ST_IDLE;
        PSF_ST_PAR_E: state_nxt = PSF_ST_IDLE;
        default:      state_nxt = PSF_ST_IDLE;
      endcase
    end
  end

  // Parser register
  always_ff @(posedge aclk) begin
    if (!aresetn) state_r <= PSF_ST_IDLE;
    else          state_r <= state_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // Print modes

  // Only bit zero of the parameter counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dstrike_r <= 1'b0;
      emph_r    <= 1'b0;
    end else begin
      if (param_g) dstrike_r <= byte_val[0];
      if (param_e) emph_r    <= byte_val[0];
    end
  end

  // No separate double-strike head: it reuses emphasis, and only
  // for the single-byte character set
  assign bold_active = emph_r | (dstrike_r & char_single_byte);

  //////////////////////////////////////////////////////////////////////////
  // Feed distance

  wire          page_mode = ctrl_r[`PSF_CTRL_PAGE_BIT];
  psf_corner_t  corner;
  assign corner = psf_corner_t'(
    ctrl_r[`PSF_CTRL_CORNER_HI:`PSF_CTRL_CORNER_LO]);

  // UR and LL corners rotate the feed onto the horizontal unit
  wire use_horiz = page_mode &&
                   (corner == PSF_CORNER_UR ||
                    corner == PSF_CORNER_LL);
  wire [15:0] unit_sel = use_horiz ? unit_x_r : unit_y_r;

  // 8 x 16 bit product fits 24 bits, widened to the feed word
  wire [23:0] feed_raw = byte_val * unit_sel;
  wire [31:0] feed_max = 32'(`PSF_FEED_MAX_UM);
  // Clamp instead of rejecting an over-long request
  wire [31:0] feed_dist = ({8'h00, feed_raw} > feed_max) ?
                          feed_max : {8'h00, feed_raw};

  // Feed order and next-line pulse, one cycle after the parameter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feed_r_out   <= '0;
      feed_r       <= 32'h0000_0000;
      line_start_r <= 1'b0;
    end else begin
      feed_r_out.valid <= param_j;
      line_start_r     <= param_j;
      if (param_j) begin
        feed_r_out.use_horiz <= use_horiz;
        feed_r_out.dist_um   <= feed_dist;
        feed_r               <= feed_dist;
      end
    end
  end

  assign feed_out   = feed_r_out;
  assign line_start = line_start_r;

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  // Address and data are taken together, one write at a time
  wire wr_take = axi_req.awvalid && axi_req.wvalid && !bvalid_r;
  wire rd_take = axi_req.arvalid && !rvalid_r;
  wire wr_ctrl = wr_take && axi_req.awaddr == `PSF_REG_CTRL;
  wire wr_unit = wr_take && axi_req.awaddr == `PSF_REG_UNIT;
  wire wr_hit  = wr_ctrl || wr_unit ||
                 axi_req.awaddr == `PSF_REG_STATUS ||
                 axi_req.awaddr == `PSF_REG_FEED;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] psf_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : psf_merge

  wire [31:0] unit_word = {unit_y_r, unit_x_r};
  wire [31:0] unit_new  = psf_merge(unit_word, axi_req.wdata,
                                    axi_req.wstrb);
  wire [31:0] ctrl_new  = psf_merge(ctrl_r, axi_req.wdata,
                                    axi_req.wstrb) & 32'h0000_0007;

  // Read decode; status shows the parser's own flags
  wire [31:0] status_word = {27'h0, state_r, emph_r, dstrike_r};
  wire        rd_hit = axi_req.araddr == `PSF_REG_CTRL ||
                       axi_req.araddr == `PSF_REG_UNIT ||
                       axi_req.araddr == `PSF_REG_STATUS ||
                       axi_req.araddr == `PSF_REG_FEED;
  wire [31:0] rd_word =
    (axi_req.araddr == `PSF_REG_CTRL)   ? ctrl_r      :
    (axi_req.araddr == `PSF_REG_UNIT)   ? unit_word   :
    (axi_req.araddr == `PSF_REG_STATUS) ? status_word :
    (axi_req.araddr == `PSF_REG_FEED)   ? feed_r      : 32'h0000_0000;

  // Software-written settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= `PSF_CTRL_RST;
      unit_x_r <= `PSF_UNIT_X_RST;
      unit_y_r <= `PSF_UNIT_Y_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= ctrl_new;
      if (wr_unit) begin
        unit_x_r <= unit_new[15:0];
        unit_y_r <= unit_new[31:16];
      end
    end
  end

  // Write answer, held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `PSF_RESP_OKAY;
    end else if (wr_take) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `PSF_RESP_OKAY : `PSF_RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read answer; unmapped reads give zero and an error code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `PSF_RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? `PSF_RESP_OKAY : `PSF_RESP_SLVERR;
      rdata_r  <= rd_word;
    end else if (axi_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Ready signals are combinational: write readies follow wr_take, read ready the pending flag
  assign axi_rsp.awready = wr_take;
  assign axi_rsp.wready  = wr_take;
  assign axi_rsp.bvalid  = bvalid_r;
  assign axi_rsp.bresp   = bresp_r;
  assign axi_rsp.arready = !rvalid_r;
  assign axi_rsp.rvalid  = rvalid_r;
  assign axi_rsp.rresp   = rresp_r;
  assign axi_rsp.rdata   = rdata_r;

endmodule : psf_cmd

// *** psf_cmd_monitor.sv ***
`timescale 1ns/1ps
// Port watcher for the command block
module psf_cmd_monitor (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire psf_pkg::psf_axi_req_t axi_req,
  input wire psf_pkg::psf_axi_rsp_t axi_rsp,
  input wire psf_pkg::psf_byte_t    host_byte,
  input wire logic                  host_ready,
  input wire logic                  char_single_byte,
  input wire logic                  bold_active,
  input wire psf_pkg::psf_feed_t    feed_out,
  input wire logic                  line_start
);
  import psf_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////
  line_pair_a: assert property (line_start == feed_out.valid)
    else $error("line start and feed pulse differ");
  feed_once_a: assert property (feed_out.valid |=> !feed_out.valid)
    else $error("feed pulse longer than one cycle");
  feed_cause_a: assert property (feed_out.valid |-> $past(host_byte.valid))
    else $error("feed without a parameter byte");
  feed_clamp_a: assert property
    (feed_out.valid |-> feed_out.dist_um <= 32'h0002_49f0)
    else $error("feed distance above limit");
  feed_hold_a: assert property
    (!feed_out.valid |-> $stable(feed_out.dist_um))
    else $error("feed distance moved without a feed");
  write_ans_a: assert property (axi_req.awvalid && axi_req.wvalid
    && !axi_rsp.bvalid |=> axi_rsp.bvalid)
    else $error("write not answered");
  read_ans_a: assert property
    (axi_req.arvalid && !axi_rsp.rvalid |=> axi_rsp.rvalid)
    else $error("read not answered");
  read_gate_a: assert property (axi_rsp.arready == !axi_rsp.rvalid)
    else $error("read address ready wrong");
endmodule : psf_cmd_monitor

bind psf_cmd psf_cmd_monitor mon (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .host_byte(host_byte), .host_ready(host_ready),
  .char_single_byte(char_single_byte), .bold_active(bold_active),
  .feed_out(feed_out), .line_start(line_start));

// *** psf_defines.svh ***
`ifndef PSF_DEFINES_SVH
`define PSF_DEFINES_SVH

// Command bytes
`define PSF_ESC_BYTE        8'h1b
`define PSF_OP_DSTRIKE      8'h47
`define PSF_OP_FEED         8'h4a
`define PSF_OP_EMPH         8'h45

// Register byte offsets
`define PSF_REG_CTRL        4'h0
`define PSF_REG_UNIT        4'h4
`define PSF_REG_STATUS      4'h8
`define PSF_REG_FEED        4'hc

// Control field positions
`define PSF_CTRL_PAGE_BIT   0
`define PSF_CTRL_CORNER_LO  1
`define PSF_CTRL_CORNER_HI  2

// Reset values (units in micrometres)
`define PSF_CTRL_RST        32'h0000_0000
`define PSF_UNIT_X_RST      16'h007d
`define PSF_UNIT_Y_RST      16'h007d

// Longest feed in millimetres and micrometres
`define PSF_FEED_MAX_MM     150
`define PSF_FEED_MAX_UM     (`PSF_FEED_MAX_MM * 1000)

// AXI responses
`define PSF_RESP_OKAY       2'b00
`define PSF_RESP_SLVERR     2'b10

`endif

// *** psf_host_model.sv ***
`timescale 1ns/1ps
// Host side: sends queued bytes, optionally with gaps
module psf_host_model (
  input wire logic aclk,
  output psf_pkg::psf_byte_t host_byte
);
  import psf_pkg::*;
  logic [7:0] q[$];      // Bytes waiting to go out
  logic       slow = 0;  // Idle cycle after each byte
  logic       gap  = 0;
  initial host_byte = '0;
  // Whole commands only: escape, opcode, one parameter
  task automatic send(input logic [7:0] op, input logic [7:0] n);
    q.push_back(8'h1b);
    q.push_back(op);
    q.push_back(n);
  endtask : send
  // Idle data toggles so a stale byte is never read as fresh
  always @(posedge aclk) begin
    if (q.size() != 0 && !gap) begin
      host_byte.valid <= 1'b1;
      host_byte.data  <= q.pop_front();
      gap             <= slow;
    end else begin
      host_byte.valid <= 1'b0;
      host_byte.data  <= ~host_byte.data;
      gap             <= 1'b0;
    end
  end
endmodule : psf_host_model

// *** psf_pkg.sv ***
package psf_pkg;

  // Print-start corner, coded as the corner command's parameter
  typedef enum logic [1:0] {
    PSF_CORNER_UL = 2'b00,
    PSF_CORNER_LL = 2'b01,
    PSF_CORNER_LR = 2'b10,
    PSF_CORNER_UR = 2'b11
  } psf_corner_t;

  // Parser states
  typedef enum logic [2:0] {
    PSF_ST_IDLE  = 3'b000,
    PSF_ST_ESC   = 3'b001,
    PSF_ST_PAR_G = 3'b010,
    PSF_ST_PAR_J = 3'b011,
    PSF_ST_PAR_E = 3'b100
  } psf_state_t;

  // Host byte stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } psf_byte_t;

  // Print-and-feed order to the engine
  typedef struct packed {
    logic        valid;
    logic        use_horiz;
    logic [31:0] dist_um;
  } psf_feed_t;

  // AXI4-Lite master-to-slave signals
  typedef struct packed {
    logic [3:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [3:0]  araddr;
    logic        arvalid;
    logic        rready;
  } psf_axi_req_t;

  // AXI4-Lite slave-to-master signals
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } psf_axi_rsp_t;

endpackage : psf_pkg

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import psf_pkg::*;
  logic aclk, aresetn, csb, host_ready, bold_active, line_start;
  psf_axi_req_t axi_req;
  psf_axi_rsp_t axi_rsp;
  psf_byte_t    host_byte;
  psf_feed_t    feed_out;
  int fail_count = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h0000_58e8;
  logic [31:0] rd, ed;
  logic [1:0]  rsp, cr;
  logic [15:0] ux, uy;
  logic [7:0]  n, m;
  logic        ds = 0, em = 0, pg = 0;
  psf_cmd uut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .host_byte(host_byte), .host_ready(host_ready),
    .char_single_byte(csb), .bold_active(bold_active),
    .feed_out(feed_out), .line_start(line_start));
  psf_host_model host (.aclk(aclk), .host_byte(host_byte));
  //////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task end_of_test;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Address and data offered together, held until taken
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1;
    axi_req.wvalid <= 1;
    axi_req.bready <= 1;
    do @(posedge aclk); while (axi_rsp.awready !== 1'b1);
    axi_req.awvalid <= 0;
    axi_req.wvalid <= 0;
    while (axi_rsp.bvalid !== 1'b1) @(posedge aclk);
    rsp = axi_rsp.bresp;
    axi_req.bready <= 0;
  endtask : wr
  task rdr(input logic [3:0] a);
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1;
    axi_req.rready <= 1;
    do @(posedge aclk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 0;
    while (axi_rsp.rvalid !== 1'b1) @(posedge aclk);
    rd = axi_rsp.rdata;
    rsp = axi_rsp.rresp;
    axi_req.rready <= 0;
  endtask : rdr
  task settle;
    while (host.q.size() != 0) @(posedge aclk);
    repeat (3) @(posedge aclk);
  endtask : settle
  // Feed distance from mode, corner and unit, then clamped
  task feed(input logic [7:0] k);
    host.send(8'h4a, k);
    do @(posedge aclk); while (feed_out.valid !== 1'b1);
    ed = k * (pg && cr[0] ? ux : uy);
    if (ed > 32'h0002_49f0) ed = 32'h0002_49f0;
    chk("dist", ed, feed_out.dist_um);
    chk("horiz", {31'h0, pg && cr[0]}, {31'h0, feed_out.use_horiz});
    chk("line", 1, {31'h0, line_start});
  endtask : feed
  //////////
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  initial begin
    aresetn = 0;
    axi_req = '0;
    csb = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rdr(4'h4);
    chk("unit", 32'h007d_007d, rd);
    chk("rresp", 2'b00, rsp);
    chk("ready", 1, {31'h0, host_ready});
    wr(4'h8, 32'hffff_ffff);
    chk("bresp_ro", 2'b00, rsp);
    rdr(4'h8);
    chk("status", 0, rd);
    wr(4'h1, 0);
    chk("bresp", 2'b10, rsp);
    // Control keeps only mode and corner bits
    wr(4'h0, 32'hffff_fff8);
    rdr(4'h0);
    chk("ctrl", 0, rd);
    // Unmapped read answers zero with an error code
    rdr(4'h2);
    chk("rd_unmap", 0, rd);
    chk("rresp_unmap", 2'b10, rsp);
    $display("test regs done");
    for (int i = 0; i < 8; i++) begin
      n = (i == 0) ? 8'hfe : (i == 1) ? 8'h01 : rnd();
      m = rnd();
      host.slow = i[0];
      host.send(8'h47, n);
      host.send(8'h45, m);
      ds = n[0];
      em = m[0];
      settle();
      rdr(4'h8);
      chk("status", {30'h0, em, ds}, rd);
      csb <= 1;
      @(posedge aclk);
      chk("bold", ds | em, bold_active);
      csb <= 0;
      @(posedge aclk);
      chk("bold_dbcs", em, bold_active);
    end
    $display("test strike done");
    for (int i = 0; i < 16; i++) begin
      pg = i[0];
      cr = i[2:1];
      ux = (i < 12) ? rnd() & 16'h01ff : 16'hffff;
      uy = (i < 12) ? rnd() & 16'h01ff : 16'hffff;
      wr(4'h0, {29'h0, cr, pg});
      wr(4'h4, {uy, ux});
      feed((i == 3) ? 8'h00 : (i == 15) ? 8'hff : rnd());
      rdr(4'hc);
      chk("feed_reg", ed, rd);
    end
    feed(8'h1b);
    host.q.push_back(8'h47);
    host.q.push_back({7'h00, ~ds});
    settle();
    rdr(4'h8);
    chk("after_feed", {30'h0, em, ds}, rd);
    // An unknown opcode takes no parameter, so the next escape counts
    host.q.push_back(8'h1b);
    host.q.push_back(8'h33);
    host.send(8'h47, {7'h00, ~ds});
    ds = ~ds;
    settle();
    rdr(4'h8);
    chk("after_other", {30'h0, em, ds}, rd);
    $display("test feed done");
    // Mid-run reset must drop both flags and the last feed
    host.send(8'h47, 8'h01);
    host.send(8'h45, 8'h01);
    settle();
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdr(4'h8);
    chk("status_rst", 0, rd);
    chk("feed_rst", 0, feed_out.dist_um);
    rdr(4'hc);
    chk("feed_reg_rst", 0, rd);
    $display("test reset done");
    end_of_test();
  end
endmodule : tb
